// *** zero_cross_detect_logic.sv ***
/*
 digital side of the zero-cross detector: synchronises the front-end sink/source
 decision, applies polarity, detects edges, keeps the sticky flag and the request.
 assumes the analog front end drives SINK_ACTIVE asynchronously and that software
 pulses FLAG_CLEAR and ENABLE_SET for one cycle; sleep does not stop CORE_CLK.
*/
// Overview of operation
// - front end high means sinking, low sourcing
// - output reads 1 while sinking, noninverted
// - invert select flips the output
// - polarity applies even when disabled
// - rising edge sets flag if enabled
// - falling edge sets flag if enabled
// - either enabled edge sets the flag
// - request needs flag and three enables
// - polarity change alone may set flag
// - set wins over simultaneous clear
// - operation continues unchanged in sleep
// - disable config low: active after reset
// - disable config high: wait for enable
// - rise enable low leaves flag alone
`timescale 1ns/1ps
`include "zcd_params.svh"

module zero_cross_detect_logic
	import zcd_pkg::*;
(
	// clock and reset
	input  wire logic CORE_CLK,
	input  wire logic NRST,
	// front end
	input  wire logic SINK_ACTIVE,
	// configuration and control
	input  wire logic CROSSING_DISABLE_CONFIG,
	input  wire logic ENABLE_SET,
	input  wire logic ENABLE_CLEAR,
	input  wire logic OUTPUT_INVERT_SELECT,
	input  wire logic RISE_IRQ_ENABLE,
	input  wire logic FALL_IRQ_ENABLE,
	input  wire logic FLAG_CLEAR,
	input  wire logic CROSSING_IRQ_ENABLE,
	input  wire logic PERIPHERAL_IRQ_ENABLE,
	input  wire logic GLOBAL_IRQ_ENABLE,
	input  wire logic SLEEP_MODE,
	// status and request
	output logic      MODULE_ACTIVE,
	output logic      CROSSING_OUTPUT_BIT,
	output logic      CROSSING_IRQ_FLAG,
	output logic      IRQ_REQUEST
);

	// ------------------------------------------------------------
	// synchroniser and polarity
	// ------------------------------------------------------------
	logic [`SYNC_STAGES-1:0] sync_ff;
	logic [`SYNC_STAGES-1:0] nxt_sync;
	logic                    out_ff;
	logic                    nxt_out;
	logic                    flag_ff;
	logic                    nxt_flag;
	logic                    irq_ff;
	logic                    nxt_irq;
	zcd_state_t              state_ff;
	zcd_state_t              nxt_state;
	logic                    active_ff;
	logic                    nxt_active;
	logic                    rise_evt;
	logic                    fall_evt;

	// sleep has no input here on purpose: nothing below may depend on it
	always_comb
	begin
		nxt_sync = {sync_ff[`SYNC_STAGES-2:0], SINK_ACTIVE};
		// polarity runs regardless of enable, so a write to it alone can edge
		nxt_out  = sync_ff[`SYNC_STAGES-1] ^ OUTPUT_INVERT_SELECT;
	end

	// ------------------------------------------------------------
	// edge detection, flag and request
	// ------------------------------------------------------------
	always_comb
	begin
		rise_evt  = RISE_IRQ_ENABLE & nxt_out & ~out_ff;
		fall_evt  = FALL_IRQ_ENABLE & ~nxt_out & out_ff;
		nxt_flag  = flag_ff;
		if (FLAG_CLEAR)
		begin
			nxt_flag = 1'b0;
		end
		if (rise_evt | fall_evt)
		begin
			nxt_flag = 1'b1;
		end
		nxt_irq = nxt_flag & CROSSING_IRQ_ENABLE & PERIPHERAL_IRQ_ENABLE
			& GLOBAL_IRQ_ENABLE;
	end

	// ------------------------------------------------------------
	// module enable state
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RESET:
			begin
				// config strap taken at the first edge after release
				if (CROSSING_DISABLE_CONFIG)
				begin
					nxt_state = ST_INACTIVE;
				end
				else
				begin
					nxt_state = ST_ACTIVE;
				end
			end
			ST_INACTIVE:
			begin
				if (ENABLE_SET)
				begin
					nxt_state = ST_ACTIVE;
				end
			end
			ST_ACTIVE:
			begin
				if (ENABLE_CLEAR && !ENABLE_SET)
				begin
					nxt_state = ST_INACTIVE;
				end
			end
			default:
			begin
				nxt_state = ST_RESET;
			end
		endcase
		// registered copy keeps the status output straight off a flop
		nxt_active = (nxt_state == ST_ACTIVE);
	end

	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			sync_ff   <= '0;
			out_ff    <= `OUT_RST_VALUE;
			flag_ff   <= `FLAG_RST_VALUE;
			irq_ff    <= `IRQ_RST_VALUE;
			state_ff  <= ST_RESET;
			active_ff <= `ENABLE_RST_VALUE;
		end
		else
		begin
			sync_ff   <= nxt_sync;
			out_ff    <= nxt_out;
			flag_ff   <= nxt_flag;
			irq_ff    <= nxt_irq;
			state_ff  <= nxt_state;
			active_ff <= nxt_active;
		end
	end

	always_comb
	begin
		MODULE_ACTIVE       = active_ff;
		CROSSING_OUTPUT_BIT = out_ff;
		CROSSING_IRQ_FLAG   = flag_ff;
		IRQ_REQUEST         = irq_ff;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_polarity;
		@(posedge CORE_CLK) disable iff (!NRST)
		$past(NRST) |->
			out_ff == ($past(sync_ff[`SYNC_STAGES-1]) ^ $past(OUTPUT_INVERT_SELECT));
	endproperty
	a_polarity: assert property (p_polarity) else $error("output polarity wrong");

	property p_sync_delay;
		@(posedge CORE_CLK) disable iff (!NRST)
		$rose(SINK_ACTIVE) ##1 SINK_ACTIVE [*3] |-> ##0 sync_ff[`SYNC_STAGES-1];
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("sync too slow");

	property p_rise_sets;
		@(posedge CORE_CLK) disable iff (!NRST)
		$rose(out_ff) && $past(RISE_IRQ_ENABLE) |-> flag_ff;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rise edge missed");

	property p_fall_sets;
		@(posedge CORE_CLK) disable iff (!NRST)
		$fell(out_ff) && $past(FALL_IRQ_ENABLE) |-> flag_ff;
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall edge missed");

	property p_no_spurious;
		@(posedge CORE_CLK) disable iff (!NRST)
		$rose(flag_ff) |-> ($rose(out_ff) && $past(RISE_IRQ_ENABLE))
			|| ($fell(out_ff) && $past(FALL_IRQ_ENABLE));
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("flag set without edge");

	property p_set_wins;
		@(posedge CORE_CLK) disable iff (!NRST)
		FLAG_CLEAR && (rise_evt || fall_evt) |=> flag_ff;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat set");

	property p_clear;
		@(posedge CORE_CLK) disable iff (!NRST)
		FLAG_CLEAR && !rise_evt && !fall_evt |=> !flag_ff;
	endproperty
	a_clear: assert property (p_clear) else $error("flag clear ignored");

	property p_hold;
		@(posedge CORE_CLK) disable iff (!NRST)
		flag_ff && !FLAG_CLEAR |=> flag_ff;
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped by itself");

	property p_irq;
		@(posedge CORE_CLK) disable iff (!NRST)
		$past(NRST) |-> IRQ_REQUEST == (CROSSING_IRQ_FLAG && $past(CROSSING_IRQ_ENABLE)
			&& $past(PERIPHERAL_IRQ_ENABLE) && $past(GLOBAL_IRQ_ENABLE));
	endproperty
	a_irq: assert property (p_irq) else $error("request gating wrong");

	property p_boot;
		@(posedge CORE_CLK) disable iff (!NRST)
		state_ff == ST_RESET |=> MODULE_ACTIVE == !$past(CROSSING_DISABLE_CONFIG);
	endproperty
	a_boot: assert property (p_boot) else $error("reset activation wrong");

	property p_wait_enable;
		@(posedge CORE_CLK) disable iff (!NRST)
		state_ff == ST_INACTIVE && !ENABLE_SET |=> !MODULE_ACTIVE;
	endproperty
	a_wait_enable: assert property (p_wait_enable) else $error("activated without enable");

	c_rise: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(flag_ff) && $rose(out_ff));
	c_fall: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(flag_ff) && $fell(out_ff));
	c_race: cover property (@(posedge CORE_CLK) disable iff (!NRST) FLAG_CLEAR && rise_evt);
	c_irq: cover property (@(posedge CORE_CLK) disable iff (!NRST) $rose(IRQ_REQUEST));

endmodule

// *** zcd_params.svh ***
/*
 constants for the zero-cross detector logic: reset values and synchroniser depth.
 assumes it is included by bare name from the package or the design file.
*/
`ifndef ZCD_PARAMS_SVH
`define ZCD_PARAMS_SVH

`define SYNC_STAGES       2
`define ENABLE_RST_VALUE  1'b0
`define FLAG_RST_VALUE    1'b0
`define IRQ_RST_VALUE     1'b0
`define OUT_RST_VALUE     1'b0

`endif

// *** zcd_pkg.sv ***
/*
 types shared by the zero-cross detector logic.
 assumes nothing of its surroundings.
*/
`include "zcd_params.svh"

package zcd_pkg;

	typedef enum logic [1:0]
	{
		ST_RESET    = 2'b00,
		ST_INACTIVE = 2'b01,
		ST_ACTIVE   = 2'b10
	} zcd_state_t;

endpackage

// *** zcd_front_end.sv ***
/*
 analog front end stand-in: compares the pin level with the crossing reference.
 assumes the bench moves pin_mv just after clock edges.
*/
`timescale 1ns/1ps
module zcd_front_end
#(
	parameter int REF_MV = 750
)
(
	// pin level in millivolts
	input  wire logic [11:0] pin_mv,
	// sink/source decision
	output logic             sink_active
);
	// sinks above the reference, sources below; sleep has no say here
	assign sink_active = (pin_mv > 12'(REF_MV));
endmodule

// *** tb_top.sv ***
/*
 self-checking bench for the zero-cross detector logic: cycle model in the bench.
 assumes the design and its front-end model compile before this file.
*/
`timescale 1ns/1ps
module tb_top
	import zcd_pkg::*;
;
	logic        CORE_CLK = 0, NRST = 0, cfg = 0, eset = 0, eclr = 0, inv = 0;
	logic        rie = 0, fie = 0, clr = 0, cie = 0, pie = 0, global_irq_enable = 0, slp = 0;
	logic [11:0] pin_mv = 0;
	logic        sink, act, outb, flag, irq;
	logic        s1, s2, e_act, e_out, e_flag, e_irq;
	int          err_count = 0, n_compared = 0, cyc = 0;

	zcd_front_end i_fe (.pin_mv(pin_mv), .sink_active(sink));
	zero_cross_detect_logic i_dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .SINK_ACTIVE(sink),
		.CROSSING_DISABLE_CONFIG(cfg), .ENABLE_SET(eset), .ENABLE_CLEAR(eclr),
		.OUTPUT_INVERT_SELECT(inv), .RISE_IRQ_ENABLE(rie), .FALL_IRQ_ENABLE(fie),
		.FLAG_CLEAR(clr), .CROSSING_IRQ_ENABLE(cie), .PERIPHERAL_IRQ_ENABLE(pie),
		.GLOBAL_IRQ_ENABLE(global_irq_enable), .SLEEP_MODE(slp), .MODULE_ACTIVE(act),
		.CROSSING_OUTPUT_BIT(outb), .CROSSING_IRQ_FLAG(flag), .IRQ_REQUEST(irq));

	initial forever #5 CORE_CLK = ~CORE_CLK;

	// the whole run needs about 2520 cycles
	always @(posedge CORE_CLK)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			err_count++;
			close_out();
		end
	end

	task check(input string name, input logic exp, input logic seen);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %b seen %b", name, exp, seen);
		end
	endtask

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function logic f_flag(input logic o, input logic n, input logic f, input logic c);
		return (n & ~o & rie) | (~n & o & fie) | (f & ~c);
	endfunction

	// one edge of the model, then compare once the design's updates have landed
	task step(input logic first);
		logic n_out;
		@(posedge CORE_CLK);
		n_out = s2 ^ inv;
		if (NRST)
		begin
			e_flag = f_flag(e_out, n_out, e_flag, clr);
			e_irq = e_flag & cie & pie & global_irq_enable;
			e_act = first ? ~cfg : (eset | (e_act & ~eclr));
			e_out = n_out;
			s2 = s1;
			s1 = sink;
		end
		#1;
		check("active", e_act, act);
		check("output", e_out, outb);
		check("flag", e_flag, flag);
		check("request", e_irq, irq);
	endtask

	task do_reset(input logic c);
		NRST = 0;
		{s1, s2, e_act, e_out, e_flag, e_irq} = '0;
		{eset, eclr, inv, rie, fie, clr, cie, pie, global_irq_enable, slp} = '0;
		cfg = c;
		repeat (5) step(0);
		NRST = 1;
		step(1);
	endtask

	initial
	begin
		void'($urandom(32'h100F));
		do_reset(1);
		rie = 1;
		inv = 1;
		step(0);
		eset = 1;
		step(0);
		eset = 0;
		$display("test inactive start done");
		do_reset(0);
		{rie, fie, cie, pie, global_irq_enable} = 5'h1F;
		inv = 1;
		clr = 1;
		step(0);
		clr = 0;
		repeat (3) step(0);
		clr = 1;
		step(0);
		clr = 0;
		slp = 1;
		inv = 0;
		step(0);
		slp = 0;
		$display("test set over clear done");
		repeat (2500)
		begin
			step(0);
			pin_mv = 12'($urandom_range(1500));
			inv = ($urandom_range(15) == 0);
			{rie, fie, cie, pie, global_irq_enable, slp} = 6'($urandom);
			clr = ($urandom_range(3) == 0);
			eset = ($urandom_range(15) == 0);
			eclr = ($urandom_range(15) == 0);
		end
		$display("test random done");
		close_out();
	end
endmodule
